// file: design/emb_top.sv
// external memory bus interface with register slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "emb_defs.svh"
module emb_top (
  // clock, reset, enable
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        CE_IN,
  // avalon-mm slave
  input  wire logic [9:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  // cpu side access port
  input  wire logic        MEM_REQ_IN,
  input  wire logic [21:0] MEM_ADDR_IN,
  input  wire logic        MEM_WRITE_IN,
  input  wire logic [7:0]  MEM_WDATA_IN,
  input  wire logic        MEM_INTERNAL_IN,
  input  wire logic        IN_SERVICE_IN,
  output logic             MEM_ACK_OUT,
  output logic      [7:0]  MEM_RDATA_OUT,
  // device straps and port alternate function selects
  input  wire logic        PORT0_AF_IN,
  input  wire logic        PORT1_AF_IN,
  input  wire logic        PORT9_AF_IN,
  input  wire logic        MMU_PRESENT_IN,
  input  wire logic        ADDR_SHARED_IN,
  input  wire logic        AS_DEDICATED_IN,
  // bus pins
  input  wire logic [7:0]  AD_IN,
  output logic      [7:0]  AD_OUT,
  output logic      [7:0]  AD_OE_OUT,
  output logic      [7:0]  ADDR_MID_OUT,
  output logic      [7:0]  ADDR_MID_OE_OUT,
  output logic      [5:0]  ADDR_TOP_OUT,
  output logic      [5:0]  ADDR_TOP_OE_OUT,
  output logic             ADDRESS_STROBE_N_OUT,
  output logic             ADDRESS_STROBE_OE_OUT,
  output logic             DATA_STROBE_N_OUT,
  output logic             SECOND_DATA_STROBE_N_OUT,
  output logic             READ_WRITE_OUT,
  input  wire logic        WAIT_N_IN,
  // configuration outputs to the core
  output logic             HIGH_DRIVE_OUT,
  output logic             SEGMENT_SAVE_OUT,
  output logic             PAGE_REMAP_OUT
);

  emb_pkg::emb_state_s r;
  emb_pkg::emb_state_s nxt;

  logic [7:0] reg_idx;
  logic       wait_en;
  logic       prot_dis;
  logic       serial_en;
  logic       tog_en;
  logic       upper;
  logic       wait_hold;
  logic [1:0] as_str;
  logic [2:0] ds_str;
  logic       addr_ph;
  logic       data_ph;
  logic       ds_wave_n;
  logic       fmt;
  logic [7:0] rd_mux;
  logic       start_vis;

  assign reg_idx   = AVS_ADDRESS_IN[9:2];
  assign wait_en   = r.busctl[`EMB_BIT_WAITEN];
  assign prot_dis  = r.busctl[`EMB_BIT_PROTDIS];
  assign serial_en = r.busctl[`EMB_BIT_SERIALEN];
  assign fmt       = r.cfg1[`EMB_BIT_FORMAT];
  assign tog_en    = r.cfg1[`EMB_BIT_TOGGLE] & prot_dis;
  assign upper     = r.addr[21];
  assign wait_hold = wait_en & ~WAIT_N_IN;
  assign as_str    = upper ? r.cfg2[`EMB_UAS_LSB +: 2] : r.cfg2[`EMB_LAS_LSB +: 2];
  assign ds_str    = upper ? r.waitctl[`EMB_UDS_LSB +: 3] : r.waitctl[`EMB_LDS_LSB +: 3];
  assign start_vis = ~MEM_INTERNAL_IN | tog_en;

  // register read mux
  always_comb begin
    case (reg_idx)
      `EMB_IDX_CFG1:    rd_mux = r.cfg1;
      `EMB_IDX_CFG2:    rd_mux = r.cfg2;
      `EMB_IDX_WAITCTL: rd_mux = r.waitctl;
      `EMB_IDX_BUSCTL:  rd_mux = r.busctl;
      `EMB_IDX_STATUS:  rd_mux = {5'h00, r.wr, r.phase};
      default:          rd_mux = 8'h00;
    endcase
  end

  // next state
  always_comb begin
    nxt            = r;
    nxt.ack        = 1'b0;
    nxt.bus_rvalid = 1'b0;
    // register slave
    if (AVS_READ_IN && !r.bus_rvalid) begin
      nxt.bus_rdata  = rd_mux;
      nxt.bus_rvalid = 1'b1;
    end
    if (AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]) begin
      case (reg_idx)
        `EMB_IDX_CFG1: begin
          nxt.cfg1                = AVS_WRITEDATA_IN[7:0];
          nxt.cfg1[7]             = 1'b1;
          nxt.cfg1[0]             = 1'b0;
          nxt.cfg1[`EMB_BIT_RSVD3] = 1'b0;
        end
        `EMB_IDX_CFG2: begin
          if (!IN_SERVICE_IN) begin
            nxt.cfg2    = AVS_WRITEDATA_IN[7:0];
            nxt.cfg2[7] = 1'b0;
          end
        end
        `EMB_IDX_WAITCTL: begin
          nxt.waitctl    = AVS_WRITEDATA_IN[7:0];
          nxt.waitctl[7] = 1'b0;
        end
        `EMB_IDX_BUSCTL: nxt.busctl = {5'h00, AVS_WRITEDATA_IN[2:0]};
        default: begin
        end
      endcase
    end
    // memory cycle sequencer
    case (r.phase)
      emb_pkg::EMB_IDLE: begin
        if (MEM_REQ_IN && !r.ack) begin
          nxt.internal = MEM_INTERNAL_IN;
          nxt.visible  = start_vis;
          if (start_vis) begin
            nxt.wr     = MEM_WRITE_IN;
            nxt.phase  = emb_pkg::EMB_ADDR;
            nxt.addr   = MEM_ADDR_IN;
            nxt.ad_q   = MEM_ADDR_IN[7:0];
            nxt.ad_drv = 1'b1;
            nxt.cnt    = {1'b0, (MEM_ADDR_IN[21] ? r.cfg2[`EMB_UAS_LSB +: 2] : r.cfg2[`EMB_LAS_LSB +: 2])};
          end else begin
            nxt.ack    = 1'b1;
          end
        end
      end
      emb_pkg::EMB_ADDR: begin
        if (r.cnt != 3'h0) begin
          nxt.cnt = r.cnt - 3'h1;
        end else if (!wait_hold) begin
          nxt.phase = emb_pkg::EMB_DATA;
          nxt.cnt   = ds_str;
          if (r.wr) begin
            nxt.ad_q = r.rdata;
          end
          nxt.ad_drv = r.wr;
        end
      end
      emb_pkg::EMB_DATA: begin
        if (r.cnt != 3'h0) begin
          nxt.cnt = r.cnt - 3'h1;
        end else if (!wait_hold) begin
          nxt.phase = emb_pkg::EMB_IDLE;
          nxt.ack   = 1'b1;
          if (!r.wr) begin
            nxt.rdata = AD_IN;
          end
        end
      end
      default: nxt.phase = emb_pkg::EMB_IDLE;
    endcase
    // write data waits in rdata until the data phase
    if (r.phase == emb_pkg::EMB_IDLE && MEM_REQ_IN && !r.ack && MEM_WRITE_IN) begin
      nxt.rdata = MEM_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      r            <= '0;
      r.phase      <= emb_pkg::EMB_IDLE;
      r.cfg1       <= `EMB_RST_CFG1;
      r.cfg2       <= `EMB_RST_CFG2;
      r.waitctl    <= `EMB_RST_WAITCTL;
      r.busctl     <= `EMB_RST_BUSCTL;
    end else if (CE_IN) begin
      r <= nxt;
    end
  end

  // pin waveforms
  assign addr_ph   = (r.phase == emb_pkg::EMB_ADDR) & r.visible;
  assign data_ph   = (r.phase == emb_pkg::EMB_DATA) & r.visible;
  assign ds_wave_n = ~(data_ph & ~r.internal & (~fmt | ~r.wr));

  always_comb begin
    if (fmt) begin
      ADDRESS_STROBE_N_OUT = addr_ph;
      READ_WRITE_OUT       = ~(data_ph & r.wr);
    end else begin
      ADDRESS_STROBE_N_OUT = ~addr_ph;
      READ_WRITE_OUT       = ~r.wr;
    end
    DATA_STROBE_N_OUT        = ds_wave_n;
    SECOND_DATA_STROBE_N_OUT = 1'b1;
    if (r.cfg1[`EMB_BIT_SECOND_STROBE_ENABLE]) begin
      if (upper) begin
        DATA_STROBE_N_OUT = ds_wave_n;
      end else begin
        DATA_STROBE_N_OUT        = 1'b1;
        SECOND_DATA_STROBE_N_OUT = ds_wave_n;
      end
    end
  end

  assign ADDRESS_STROBE_OE_OUT = AS_DEDICATED_IN | r.cfg1[`EMB_BIT_ASPIN];
  assign AD_OUT                = r.ad_q;
  assign AD_OE_OUT             = {8{PORT0_AF_IN & r.ad_drv}};
  assign ADDR_MID_OUT          = r.addr[15:8];
  assign ADDR_MID_OE_OUT       = {8{PORT1_AF_IN}};
  assign ADDR_TOP_OUT          = r.addr[21:16];

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_top
      if (gi == 1 || gi == 2) begin : g_shared
        assign ADDR_TOP_OE_OUT[gi] = PORT9_AF_IN & MMU_PRESENT_IN & ~(ADDR_SHARED_IN & serial_en);
      end else begin : g_plain
        assign ADDR_TOP_OE_OUT[gi] = PORT9_AF_IN & MMU_PRESENT_IN;
      end
    end
  endgenerate

  assign HIGH_DRIVE_OUT      = r.cfg1[`EMB_BIT_HIDRIVE];
  assign SEGMENT_SAVE_OUT    = r.cfg2[`EMB_BIT_SEGSAVE];
  assign PAGE_REMAP_OUT      = r.cfg2[`EMB_BIT_REMAP];
  assign MEM_ACK_OUT         = r.ack;
  assign MEM_RDATA_OUT       = r.rdata;
  assign AVS_READDATA_OUT    = {24'h000000, r.bus_rdata};
  assign AVS_WAITREQUEST_OUT = AVS_READ_IN & ~r.bus_rvalid;

endmodule

// file: design/emb_defs.svh
// constants of the external memory bus interface
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH
`define EMB_IDX_CFG1      8'hF5
`define EMB_IDX_CFG2      8'hF6
`define EMB_IDX_WAITCTL   8'hF7
`define EMB_IDX_BUSCTL    8'hF8
`define EMB_IDX_STATUS    8'hF9
`define EMB_RST_CFG1      8'h80
`define EMB_RST_CFG2      8'h1F
`define EMB_RST_WAITCTL   8'h7F
`define EMB_RST_BUSCTL    8'h00
`define EMB_BIT_FORMAT    6
`define EMB_BIT_SECOND_STROBE_ENABLE     5
`define EMB_BIT_ASPIN     4
`define EMB_BIT_RSVD3     3
`define EMB_BIT_TOGGLE    2
`define EMB_BIT_HIDRIVE   1
`define EMB_BIT_SEGSAVE   6
`define EMB_BIT_REMAP     5
`define EMB_LAS_LSB       2
`define EMB_UAS_LSB       0
`define EMB_LDS_LSB       0
`define EMB_UDS_LSB       3
`define EMB_BIT_WAITEN    0
`define EMB_BIT_PROTDIS   1
`define EMB_BIT_SERIALEN  2
`endif

// file: design/emb_pkg.sv
// types of the external memory bus interface
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_IDLE = 2'b00,
    EMB_ADDR = 2'b01,
    EMB_DATA = 2'b10
  } emb_phase_e;

  typedef struct packed {
    emb_phase_e  phase;
    logic [2:0]  cnt;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  waitctl;
    logic [7:0]  busctl;
    logic [21:0] addr;
    logic        wr;
    logic        internal;
    logic        visible;
    logic [7:0]  ad_q;
    logic        ad_drv;
    logic [7:0]  rdata;
    logic        ack;
    logic [7:0]  bus_rdata;
    logic        bus_rvalid;
  } emb_state_s;
endpackage

// file: testbench/emb_top_sva.sv
// assertions on the bus pins and ports
`timescale 1ns/1ps
module emb_top_sva (
  // clock and reset
  input wire logic       CLK_SYS_IN,
  input wire logic       RESET_N_IN,
  // watched ports
  input wire logic       AVS_WRITE_IN,
  input wire logic       AVS_WAITREQUEST_OUT,
  input wire logic       MEM_ACK_OUT,
  input wire logic       PORT0_AF_IN,
  input wire logic       PORT1_AF_IN,
  input wire logic       PORT9_AF_IN,
  input wire logic       MMU_PRESENT_IN,
  input wire logic       ADDR_SHARED_IN,
  input wire logic       AS_DEDICATED_IN,
  input wire logic [7:0] AD_OE_OUT,
  input wire logic [7:0] ADDR_MID_OE_OUT,
  input wire logic [5:0] ADDR_TOP_OE_OUT,
  input wire logic       ADDRESS_STROBE_OE_OUT,
  input wire logic       DATA_STROBE_N_OUT,
  input wire logic       SECOND_DATA_STROBE_N_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_ack; MEM_ACK_OUT |=> !MEM_ACK_OUT; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_end; $rose(DATA_STROBE_N_OUT) |-> MEM_ACK_OUT; endproperty
  a_end: assert property (p_end) else $error("strobe end without ack");
  property p_end2; $rose(SECOND_DATA_STROBE_N_OUT) |-> MEM_ACK_OUT; endproperty
  a_end2: assert property (p_end2) else $error("second strobe end without ack");
  property p_excl; !DATA_STROBE_N_OUT |-> SECOND_DATA_STROBE_N_OUT; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_ad; AD_OE_OUT != 8'h00 |-> PORT0_AF_IN; endproperty
  a_ad: assert property (p_ad) else $error("low bus driven");
  property p_mid; ADDR_MID_OE_OUT == {8{PORT1_AF_IN}}; endproperty
  a_mid: assert property (p_mid) else $error("mid address enable");
  property p_top; ADDR_TOP_OE_OUT[0] == (PORT9_AF_IN & MMU_PRESENT_IN); endproperty
  a_top: assert property (p_top) else $error("top address enable");
  property p_topall; !ADDR_SHARED_IN |-> ADDR_TOP_OE_OUT == {6{PORT9_AF_IN & MMU_PRESENT_IN}}; endproperty
  a_topall: assert property (p_topall) else $error("top address enables differ");
  property p_aspin; AS_DEDICATED_IN |-> ADDRESS_STROBE_OE_OUT; endproperty
  a_aspin: assert property (p_aspin) else $error("strobe pin off");
  property p_wr; AVS_WRITE_IN |-> !AVS_WAITREQUEST_OUT; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  c_ack: cover property (MEM_ACK_OUT);
  c_ds: cover property (!DATA_STROBE_N_OUT);
  c_ds2: cover property (!SECOND_DATA_STROBE_N_OUT);
endmodule

// file: testbench/emb_mem_model.sv
// external memory and address latch on the bus pins
`timescale 1ns/1ps
module emb_mem_model (
  // clock and mode
  input  wire logic       clk_in,
  input  wire logic       fmt_in,
  input  wire logic [3:0] waits_in,
  // bus pins
  input  wire logic [7:0] ad_in,
  input  wire logic [7:0] ad_oe_in,
  input  wire logic       as_n_in,
  input  wire logic       ds_n_in,
  input  wire logic       ds2_n_in,
  input  wire logic       rw_in,
  output logic      [7:0] ad_out,
  output logic            wait_n_out
);
  logic [7:0] mem [256];
  logic [7:0] a_r, d_r;
  logic [7:0] last_r = 8'h00;
  logic [3:0] wc_r = 4'h0;
  logic [3:0] wa_r = 4'h0;
  logic       st, st_q, wr_q, as_act;
  assign st = !(ds_n_in & ds2_n_in) | (fmt_in & !rw_in);
  assign as_act = fmt_in ? as_n_in : !as_n_in;
  assign ad_out = (st && ad_oe_in == 8'h00) ? mem[a_r] : ~last_r;
  assign wait_n_out = !((st && wc_r < waits_in) || (as_act && wa_r < waits_in));
  always_ff @(posedge clk_in) begin
    if (as_act) a_r <= ad_in;
    wa_r <= as_act ? wa_r + 4'h1 : 4'h0;
    if (st) d_r <= ad_in;
    st_q <= st;
    wr_q <= !rw_in;
    if (st_q && !st && wr_q) mem[a_r] <= d_r;
    wc_r <= st ? wc_r + 4'h1 : 4'h0;
    last_r <= ad_out;
  end
endmodule

// file: testbench/emb_top_tb.sv
// self-checking bench of the external memory bus interface
`timescale 1ns/1ps
`include "emb_defs.svh"
module emb_top_tb;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, req = 0, mw = 0, mi = 0, svc = 0, af = 1, fmt = 0;
  logic [9:0] aa = 0;
  logic [31:0] awd = 0, ard, rdat;
  logic [21:0] ma = 0;
  logic [7:0] md = 0, adi, ado, adoe, mrd;
  logic [3:0] waits = 0;
  logic wrq, ack, asn, dsn, ds2n, rwo, asoe, hd, ss, pr, wt, dsl, ds2l;
  logic shr = 0, asd = 0;
  logic [5:0] toe;
  int n_errors = 0, checks_done = 0, n;
  emb_top dut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .AVS_ADDRESS_IN(aa),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hF), .AVS_WRITEDATA_IN(awd),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wrq), .MEM_REQ_IN(req), .MEM_ADDR_IN(ma),
    .MEM_WRITE_IN(mw), .MEM_WDATA_IN(md), .MEM_INTERNAL_IN(mi), .IN_SERVICE_IN(svc),
    .MEM_ACK_OUT(ack), .MEM_RDATA_OUT(mrd), .PORT0_AF_IN(af), .PORT1_AF_IN(af), .PORT9_AF_IN(af),
    .MMU_PRESENT_IN(1'b1), .ADDR_SHARED_IN(shr), .AS_DEDICATED_IN(asd), .AD_IN(adi),
    .AD_OUT(ado), .AD_OE_OUT(adoe), .ADDR_MID_OUT(), .ADDR_MID_OE_OUT(), .ADDR_TOP_OUT(),
    .ADDR_TOP_OE_OUT(toe), .ADDRESS_STROBE_N_OUT(asn), .ADDRESS_STROBE_OE_OUT(asoe),
    .DATA_STROBE_N_OUT(dsn), .SECOND_DATA_STROBE_N_OUT(ds2n), .READ_WRITE_OUT(rwo),
    .WAIT_N_IN(wt), .HIGH_DRIVE_OUT(hd), .SEGMENT_SAVE_OUT(ss), .PAGE_REMAP_OUT(pr));
  emb_mem_model mem (.clk_in(clk), .fmt_in(fmt), .waits_in(waits), .ad_in(ado), .ad_oe_in(adoe),
    .as_n_in(asn), .ds_n_in(dsn), .ds2_n_in(ds2n), .rw_in(rwo), .ad_out(adi), .wait_n_out(wt));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic avw(input logic [7:0] i, d);
    @(posedge clk);
    aa <= {i, 2'b00};
    awd <= {24'h0, d};
    wr <= 1'b1;
    do @(posedge clk); while (wrq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic avr(input logic [7:0] i, e);
    @(posedge clk);
    aa <= {i, 2'b00};
    rd <= 1'b1;
    do @(posedge clk); while (wrq !== 1'b0);
    ard = rdat;
    rd <= 1'b0;
    chk(ard, {24'h0, e});
  endtask
  task automatic macc(input logic [21:0] a, input logic w, input logic [7:0] d, input logic i,
                      input logic [7:0] e, input int k);
    @(posedge clk);
    ma <= a;
    mw <= w;
    md <= d;
    mi <= i;
    req <= 1'b1;
    n = 0;
    dsl = 0;
    ds2l = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      dsl |= !dsn;
      ds2l |= !ds2n;
    end while (ack !== 1'b1 && n < 100);
    if (k > 0) chk(n, k);
    if (!w) chk(mrd, e);
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    avr(`EMB_IDX_CFG1, 8'h80);
    avr(`EMB_IDX_CFG2, 8'h1F);
    avr(8'h10, 8'h00);
    macc(22'h000012, 1, 8'h5A, 0, 0, 13);
    chk({dsl, ds2l}, 2'b10);
    $display("test reset stretch done");
    avw(`EMB_IDX_WAITCTL, 8'h00);
    avw(`EMB_IDX_CFG2, 8'h12);
    macc(22'h200012, 0, 0, 0, 8'h5A, 5);
    waits <= 4'h2;
    avw(`EMB_IDX_BUSCTL, 8'h01);
    macc(22'h000012, 0, 0, 0, 8'h5A, 7);
    avw(`EMB_IDX_BUSCTL, 8'h00);
    macc(22'h000012, 0, 0, 0, 8'h5A, 3);
    $display("test wait done");
    avw(`EMB_IDX_CFG1, 8'hA0);
    macc(22'h000012, 0, 0, 0, 8'h5A, 3);
    chk({dsl, ds2l}, 2'b01);
    macc(22'h200012, 0, 0, 0, 8'h5A, 5);
    chk({dsl, ds2l}, 2'b10);
    avw(`EMB_IDX_CFG1, 8'hC0);
    fmt <= 1'b1;
    macc(22'h000034, 1, 8'hC3, 0, 0, 3);
    macc(22'h000034, 0, 0, 0, 8'hC3, 3);
    macc(22'h000034, 0, 0, 1, 8'hC3, 1);
    chk({dsl, ds2l}, 2'b00);
    avw(`EMB_IDX_BUSCTL, 8'h02);
    avw(`EMB_IDX_CFG1, 8'h84);
    fmt <= 1'b0;
    macc(22'h000034, 1, 8'h11, 1, 0, 3);
    chk({dsl, ds2l}, 2'b00);
    avr(`EMB_IDX_STATUS, 8'h04);
    $display("test strobes done");
    avw(`EMB_IDX_CFG1, 8'hFF);
    avr(`EMB_IDX_CFG1, 8'hF6);
    chk({hd, asoe}, 2'b11);
    svc <= 1'b1;
    avw(`EMB_IDX_CFG2, 8'h00);
    avr(`EMB_IDX_CFG2, 8'h12);
    svc <= 1'b0;
    avw(`EMB_IDX_CFG2, 8'hFF);
    avr(`EMB_IDX_CFG2, 8'h7F);
    chk({ss, pr}, 2'b11);
    avw(`EMB_IDX_BUSCTL, 8'h04);
    shr <= 1'b1;
    asd <= 1'b1;
    avw(`EMB_IDX_CFG1, 8'h80);
    chk({toe, asoe}, 7'h73);
    shr <= 1'b0;
    asd <= 1'b0;
    @(posedge clk);
    #1;
    chk({toe, asoe}, 7'h7E);
    af <= 1'b0;
    @(posedge clk);
    af <= 1'b1;
    $display("test registers done");
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule
bind emb_top emb_top_sva u_sva (.CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .MEM_ACK_OUT(MEM_ACK_OUT),
  .PORT0_AF_IN(PORT0_AF_IN), .PORT1_AF_IN(PORT1_AF_IN), .PORT9_AF_IN(PORT9_AF_IN),
  .MMU_PRESENT_IN(MMU_PRESENT_IN), .ADDR_SHARED_IN(ADDR_SHARED_IN), .AS_DEDICATED_IN(AS_DEDICATED_IN),
  .AD_OE_OUT(AD_OE_OUT),
  .ADDR_MID_OE_OUT(ADDR_MID_OE_OUT), .ADDR_TOP_OE_OUT(ADDR_TOP_OE_OUT),
  .ADDRESS_STROBE_OE_OUT(ADDRESS_STROBE_OE_OUT), .DATA_STROBE_N_OUT(DATA_STROBE_N_OUT),
  .SECOND_DATA_STROBE_N_OUT(SECOND_DATA_STROBE_N_OUT));
